/* uart_cmd_defines.svh */
/*
  Constants for the host serial port: register offsets, reset values,
  limits and timing counts. Definitions only; included by bare name.
*/
`ifndef UART_CMD_DEFINES_SVH
`define UART_CMD_DEFINES_SVH

`define CLK_HZ 32'd10000000
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define STEP_MS 7'd100

`define OFS_API_MODE 6'h00
`define OFS_OUT_OPT 6'h04
`define OFS_BAUD 6'h08
`define OFS_PARITY 6'h0c
`define OFS_STOP 6'h10
`define OFS_PKT_TO 6'h14
`define OFS_ESC 6'h18
`define OFS_GUARD 6'h1c
`define OFS_CMD_TO 6'h20
`define OFS_RTS_FN 6'h24
`define OFS_CONTROL 6'h28
`define OFS_STATUS 6'h2c

`define RST_BAUD 20'h00003
`define RST_PKT_TO 8'h03
`define RST_ESC 8'h2b
`define RST_GUARD 12'h3e8
`define RST_CMD_TO 10'h064
`define GUARD_MIN 12'h002
`define GUARD_MAX 12'hce4
`define CMD_TO_MIN 10'h002
`define CMD_TO_MAX 10'h28f
`define BAUD_STD_MAX 20'h0000a
`define BAUD_CUS_MIN 20'h0012c
`define BAUD_CUS_MAX 20'hec400
`define FRAME_NATIVE 8'h90
`define FRAME_EXPLICIT 8'h91

`endif

/* uart_cmd_pkg.sv */
/*
  Types and shared arithmetic for the host serial port.
  Assumes the defines header is available on the include path.
*/
`include "uart_cmd_defines.svh"

package uart_cmd_pkg;

  typedef enum logic [1:0] {
    API_TRANSPARENT = 2'h0,
    API_FRAMED = 2'h1,
    API_FRAMED_ESC = 2'h2
  } api_mode_e;

  typedef enum logic [1:0] {
    ESC_IDLE = 2'h0,
    ESC_COUNT = 2'h1,
    ESC_AFTER = 2'h2
  } esc_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PAR = 3'h3,
    RX_STOP = 3'h4
  } rx_state_e;

  typedef struct packed {
    logic [19:0] baud;
    logic [1:0] parity;
    logic two_stop;
  } frame_cfg_s;

  // Bit rate selected by a code; standard codes via table
  function automatic logic [19:0] rate_of(input logic [19:0] code);
    case (code[3:0])
      4'h0: rate_of = 20'd1200;
      4'h1: rate_of = 20'd2400;
      4'h2: rate_of = 20'd4800;
      4'h3: rate_of = 20'd9600;
      4'h4: rate_of = 20'd19200;
      4'h5: rate_of = 20'd38400;
      4'h6: rate_of = 20'd57600;
      4'h7: rate_of = 20'd115200;
      4'h8: rate_of = 20'd230400;
      4'h9: rate_of = 20'd460800;
      default: rate_of = 20'd921600;
    endcase
    if (code > `BAUD_STD_MAX) begin
      rate_of = code;
    end
  endfunction

  // Rounded clock divisor for a bit rate
  function automatic logic [15:0] div_of(input logic [19:0] rate);
    logic [31:0] q;
    q = (`CLK_HZ + {13'h0, rate[19:1]}) / {12'h0, rate};
    div_of = q[15:0];
  endfunction

endpackage

/* serial_rx.sv */
/*
  Receiver for one serial character, LSB first, 8 data bits.
  Assumes rxd_i is already synchronous and the divisor is at least 4.
*/
`timescale 1ns/100ps
`default_nettype none

module serial_rx (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rxd_i,
  input wire logic [15:0] div_i,
  input wire logic parity_en_i,
  input wire logic two_stop_i,
  output logic [7:0] data_o,
  output logic valid_o,
  output logic busy_o
);

  uart_cmd_pkg::rx_state_e st_r, st_nxt;
  logic [15:0] cyc_r, cyc_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic valid_nxt;

  always_comb begin
    st_nxt = st_r;
    cyc_nxt = cyc_r - 16'h1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    valid_nxt = 1'b0;
    case (st_r)
      uart_cmd_pkg::RX_IDLE: begin
        cyc_nxt = {1'b0, div_i[15:1]};
        bit_nxt = 3'h0;
        if (!rxd_i) begin
          st_nxt = uart_cmd_pkg::RX_START;
        end
      end
      uart_cmd_pkg::RX_START: begin
        if (cyc_r == 16'h0) begin
          cyc_nxt = div_i - 16'h1;
          // A glitch shorter than half a bit is not a start
          st_nxt = rxd_i ? uart_cmd_pkg::RX_IDLE : uart_cmd_pkg::RX_DATA;
        end
      end
      uart_cmd_pkg::RX_DATA: begin
        if (cyc_r == 16'h0) begin
          cyc_nxt = div_i - 16'h1;
          sh_nxt = {rxd_i, sh_r[7:1]};
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            st_nxt = parity_en_i ? uart_cmd_pkg::RX_PAR :
                                   uart_cmd_pkg::RX_STOP;
          end
        end
      end
      uart_cmd_pkg::RX_PAR: begin
        // Parity slot is skipped, never checked
        if (cyc_r == 16'h0) begin
          cyc_nxt = div_i - 16'h1;
          st_nxt = uart_cmd_pkg::RX_STOP;
        end
      end
      uart_cmd_pkg::RX_STOP: begin
        if (cyc_r == 16'h0) begin
          cyc_nxt = div_i - 16'h1;
          bit_nxt = bit_r + 3'h1;
          if (!two_stop_i || bit_r == 3'h1) begin
            st_nxt = uart_cmd_pkg::RX_IDLE;
            valid_nxt = rxd_i;
          end
        end
      end
      default: st_nxt = uart_cmd_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= uart_cmd_pkg::RX_IDLE;
      cyc_r <= 16'h0;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      valid_o <= 1'b0;
      data_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cyc_r <= cyc_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      valid_o <= valid_nxt;
      data_o <= sh_nxt;
      busy_o <= (st_nxt != uart_cmd_pkg::RX_IDLE);
    end
  end

endmodule

`default_nettype wire

/* host_uart_command_mode.sv */
/*
  Host serial port: framing settings, packetization by silence, guarded
  escape into command mode, command idle timeout and exit, API mode and
  receive frame type selection, RTS pin function; Wishbone register slave.
  Assumes host characters arrive on rxd_i synchronous to core_clk_i and a
  command parser pulses cmd_ok_i for each valid command.
*/
// Operation
// RULE_01: API mode 0 transparent, 1 framed, 2 framed with escaping.
// RULE_02: Framed mode emits native frame type unless any option bit set.
// RULE_03: Host writes zero to unused output option bits.
// RULE_04: Baud codes 0x0 to 0xA map to 1200 through 921600 b/s.
// RULE_05: Custom baud code used literally, rounded; readback shows real rate.
// RULE_06: Baud code resets to the 9600 b/s code.
// RULE_07: Parity setting 0 none, 1 even, 2 odd; default none.
// RULE_08: Parity slot framed only; never computed nor checked.
// RULE_09: Stop setting 0 gives one stop bit, 1 gives two.
// RULE_10: Transparent data sent after configured character times of silence.
// RULE_11: Character time is one character at the active baud rate.
// RULE_12: Zero packetization timeout forwards each character at once.
// RULE_13: Packetization timeout ignored in framed API mode.
// RULE_14: Three escape characters between guard silences enter command mode.
// RULE_15: Escape character 0 to 0xFF, default 0x2B.
// RULE_16: Guard time in ms, 0x2 to 0xCE4, default 0x3E8.
// RULE_17: No valid command within timeout leaves command mode silently.
// RULE_18: Command timeout accepts 2 to 0x28F, default 0x64.
// RULE_19: Exit command leaves command mode and applies pending changes.
// RULE_20: RTS function 0 off, 1 flow, 3 input, 4 low, 5 high. Code drives the pin only for 4 and 5, so 1 acts as 0.
// RULE_21: Command timeout counts in 100 ms steps.
// RULE_22: Baud, parity, stop settings stay pending until applied.
`timescale 1ns/100ps
`default_nettype none
`include "uart_cmd_defines.svh"

module host_uart_command_mode #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic cmd_ok_i,
  input wire logic rts_i,
  output logic rts_o,
  output logic rts_oe_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_cmd_o,
  output logic pkt_send_o,
  output logic [7:0] frame_type_o,
  output logic cmd_mode_o
);

  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Configuration and bus
  logic [1:0] api_r, api_nxt;
  logic [7:0] opt_r, opt_nxt;
  uart_cmd_pkg::frame_cfg_s pend_r, pend_nxt, act_r, act_nxt;
  logic [7:0] pkt_to_r, pkt_to_nxt, esc_r, esc_nxt;
  logic [11:0] guard_r, guard_nxt;
  logic [9:0] cmd_to_r, cmd_to_nxt;
  logic [2:0] rts_fn_r, rts_fn_nxt;
  logic [15:0] div_r, div_nxt;
  logic [19:0] char_cyc_r, char_cyc_nxt;
  logic [31:0] rdat_nxt, wdat;
  logic ack_nxt, wr, leave_wr;
  logic cmd_mode_r, cmd_mode_nxt;

  logic [7:0] ch;
  logic ch_valid, line_busy;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  always_comb begin
    wdat = wb_dat_i;
    for (int i = 0; i < 4; i++) begin
      if (!wb_sel_i[i]) begin
        wdat[i*8 +: 8] = 8'h00;
      end
    end
  end

  always_comb begin
    api_nxt = api_r;
    opt_nxt = opt_r;
    pend_nxt = pend_r;
    act_nxt = act_r;
    pkt_to_nxt = pkt_to_r;
    esc_nxt = esc_r;
    guard_nxt = guard_r;
    cmd_to_nxt = cmd_to_r;
    rts_fn_nxt = rts_fn_r;
    leave_wr = 1'b0;
    ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
    if (wr) begin
      case (wb_adr_i)
        `OFS_API_MODE: if (wdat[7:0] <= 8'h02) api_nxt = wdat[1:0]; // RULE_01
        `OFS_OUT_OPT: opt_nxt = wdat[7:0];
        `OFS_BAUD: begin
          if (wdat[31:20] == 12'h0 && wdat[19:0] <= `BAUD_STD_MAX) begin
            pend_nxt.baud = wdat[19:0]; // RULE_04
          end else if (wdat[31:20] == 12'h0 &&
                       wdat[19:0] >= `BAUD_CUS_MIN &&
                       wdat[19:0] <= `BAUD_CUS_MAX) begin
            // Store the rate the divisor really gives
            pend_nxt.baud = 20'(`CLK_HZ /
              {16'h0, uart_cmd_pkg::div_of(wdat[19:0])}); // RULE_05
          end
        end
        `OFS_PARITY: if (wdat[7:0] <= 8'h02) pend_nxt.parity = wdat[1:0]; // RULE_07
        `OFS_STOP: if (wdat[7:0] <= 8'h01) pend_nxt.two_stop = wdat[0]; // RULE_09
        `OFS_PKT_TO: pkt_to_nxt = wdat[7:0]; // RULE_10
        `OFS_ESC: esc_nxt = wdat[7:0]; // RULE_15
        `OFS_GUARD: begin
          if (wdat[31:12] == 20'h0 && wdat[11:0] >= `GUARD_MIN &&
              wdat[11:0] <= `GUARD_MAX) begin
            guard_nxt = wdat[11:0]; // RULE_16
          end
        end
        `OFS_CMD_TO: begin
          if (wdat[31:10] == 22'h0 && wdat[9:0] >= `CMD_TO_MIN &&
              wdat[9:0] <= `CMD_TO_MAX) begin
            cmd_to_nxt = wdat[9:0]; // RULE_18
          end
        end
        `OFS_RTS_FN: begin
          if (wdat[7:0] <= 8'h05 && wdat[7:0] != 8'h02) begin
            rts_fn_nxt = wdat[2:0]; // RULE_20
          end
        end
        `OFS_CONTROL: leave_wr = wdat[0];
        default: ;
      endcase
    end
    if (leave_wr) begin
      act_nxt = pend_r; // RULE_19 RULE_22
    end
  end

  always_comb begin
    case (wb_adr_i)
      `OFS_API_MODE: rdat_nxt = {30'h0, api_r};
      `OFS_OUT_OPT: rdat_nxt = {24'h0, opt_r};
      `OFS_BAUD: rdat_nxt = {12'h0, pend_r.baud};
      `OFS_PARITY: rdat_nxt = {30'h0, pend_r.parity};
      `OFS_STOP: rdat_nxt = {31'h0, pend_r.two_stop};
      `OFS_PKT_TO: rdat_nxt = {24'h0, pkt_to_r};
      `OFS_ESC: rdat_nxt = {24'h0, esc_r};
      `OFS_GUARD: rdat_nxt = {20'h0, guard_r};
      `OFS_CMD_TO: rdat_nxt = {22'h0, cmd_to_r};
      `OFS_RTS_FN: rdat_nxt = {29'h0, rts_fn_r};
      `OFS_STATUS: rdat_nxt = {29'h0, line_busy, rts_i, cmd_mode_r};
      default: rdat_nxt = 32'h0;
    endcase
    if (!(wb_cyc_i && wb_stb_i && !wb_ack_o)) begin
      rdat_nxt = 32'h0;
    end
  end

  // Divisor and character time follow the active framing only
  always_comb begin
    logic [4:0] bits;
    bits = 5'd10 + {4'h0, act_r.parity != 2'h0} + {4'h0, act_r.two_stop};
    div_nxt = uart_cmd_pkg::div_of(uart_cmd_pkg::rate_of(act_r.baud)); // RULE_04
    char_cyc_nxt = 20'(div_r * bits); // RULE_11
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      api_r <= 2'h0;
      opt_r <= 8'h00;
      pend_r <= '{baud: `RST_BAUD, parity: 2'h0, two_stop: 1'b0}; // RULE_06
      act_r <= '{baud: `RST_BAUD, parity: 2'h0, two_stop: 1'b0};
      pkt_to_r <= `RST_PKT_TO;
      esc_r <= `RST_ESC;
      guard_r <= `RST_GUARD;
      cmd_to_r <= `RST_CMD_TO;
      rts_fn_r <= 3'h0;
      div_r <= 16'h0412;
      char_cyc_r <= 20'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      api_r <= api_nxt;
      opt_r <= opt_nxt;
      pend_r <= pend_nxt;
      act_r <= act_nxt;
      pkt_to_r <= pkt_to_nxt;
      esc_r <= esc_nxt;
      guard_r <= guard_nxt;
      cmd_to_r <= cmd_to_nxt;
      rts_fn_r <= rts_fn_nxt;
      div_r <= div_nxt;
      char_cyc_r <= char_cyc_nxt;
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdat_nxt;
    end
  end

  serial_rx u_rx (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .rxd_i(rxd_i),
    .div_i(div_r),
    .parity_en_i(act_r.parity != 2'h0), // RULE_08
    .two_stop_i(act_r.two_stop), // RULE_09
    .data_o(ch),
    .valid_o(ch_valid),
    .busy_o(line_busy)
  );

  // Escape detection and command mode timing
  uart_cmd_pkg::esc_state_e esc_st_r, esc_st_nxt;
  logic [1:0] esc_cnt_r, esc_cnt_nxt;
  logic [31:0] ms_cyc_r, ms_cyc_nxt;
  logic [11:0] idle_ms_r, idle_ms_nxt;
  logic [6:0] step_ms_r, step_ms_nxt;
  logic [9:0] steps_r, steps_nxt;
  logic ms_tick, guard_met, quiet_before_r, quiet_before_nxt;

  assign ms_tick = (ms_cyc_r == 32'(MS_CYCLES - 1));
  assign guard_met = (idle_ms_r >= guard_r);

  always_comb begin
    esc_st_nxt = esc_st_r;
    esc_cnt_nxt = esc_cnt_r;
    cmd_mode_nxt = cmd_mode_r;
    ms_cyc_nxt = ms_tick ? 32'h0 : ms_cyc_r + 32'h1;
    idle_ms_nxt = idle_ms_r;
    step_ms_nxt = step_ms_r;
    steps_nxt = steps_r;
    quiet_before_nxt = guard_met || (quiet_before_r && !ch_valid); // RULE_14
    if (ms_tick && idle_ms_r != 12'hfff) begin
      idle_ms_nxt = idle_ms_r + 12'h1;
    end
    if (ch_valid || line_busy) begin
      // Silence is measured from the end of the last character
      idle_ms_nxt = 12'h0;
      ms_cyc_nxt = 32'h0;
    end
    if (!cmd_mode_r) begin
      case (esc_st_r)
        uart_cmd_pkg::ESC_IDLE: begin
          if (ch_valid && ch == esc_r && quiet_before_r) begin
            esc_st_nxt = uart_cmd_pkg::ESC_COUNT; // RULE_14
            esc_cnt_nxt = 2'h1;
          end
        end
        uart_cmd_pkg::ESC_COUNT: begin
          if (ch_valid) begin
            esc_cnt_nxt = esc_cnt_r + 2'h1;
            if (ch != esc_r) begin
              esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
            end else if (esc_cnt_r == 2'h2) begin
              esc_st_nxt = uart_cmd_pkg::ESC_AFTER; // RULE_14
            end
          end else if (guard_met) begin
            esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
          end
        end
        uart_cmd_pkg::ESC_AFTER: begin
          if (ch_valid) begin
            esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
          end else if (guard_met) begin
            esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
            cmd_mode_nxt = 1'b1; // RULE_14
            step_ms_nxt = 7'h0;
            steps_nxt = 10'h0;
          end
        end
        default: esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
      endcase
    end else begin
      esc_st_nxt = uart_cmd_pkg::ESC_IDLE;
      if (ms_tick) begin
        step_ms_nxt = (step_ms_r == `STEP_MS - 7'h1) ? 7'h0 :
                      step_ms_r + 7'h1; // RULE_21
        if (step_ms_r == `STEP_MS - 7'h1) begin
          steps_nxt = steps_r + 10'h1;
        end
      end
      if (steps_r >= cmd_to_r) begin
        cmd_mode_nxt = 1'b0; // RULE_17
      end
      if (cmd_ok_i) begin
        step_ms_nxt = 7'h0;
        steps_nxt = 10'h0;
      end
    end
    if (leave_wr) begin
      cmd_mode_nxt = 1'b0; // RULE_19
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      esc_st_r <= uart_cmd_pkg::ESC_IDLE;
      esc_cnt_r <= 2'h0;
      cmd_mode_r <= 1'b0;
      ms_cyc_r <= 32'h0;
      idle_ms_r <= 12'hfff;
      quiet_before_r <= 1'b1;
      step_ms_r <= 7'h0;
      steps_r <= 10'h0;
    end else begin
      esc_st_r <= esc_st_nxt;
      esc_cnt_r <= esc_cnt_nxt;
      cmd_mode_r <= cmd_mode_nxt;
      ms_cyc_r <= ms_cyc_nxt;
      idle_ms_r <= idle_ms_nxt;
      quiet_before_r <= quiet_before_nxt;
      step_ms_r <= step_ms_nxt;
      steps_r <= steps_nxt;
    end
  end

  // Packetization and outputs
  logic [19:0] sil_cyc_r, sil_cyc_nxt;
  logic [7:0] sil_ch_r, sil_ch_nxt;
  logic held_r, held_nxt, send_nxt, transp;
  logic [7:0] ftype_nxt;

  assign transp = (api_r == 2'(uart_cmd_pkg::API_TRANSPARENT));

  always_comb begin
    sil_cyc_nxt = sil_cyc_r + 20'h1;
    sil_ch_nxt = sil_ch_r;
    held_nxt = held_r;
    send_nxt = 1'b0;
    if (sil_cyc_r >= char_cyc_r - 20'h1) begin
      sil_cyc_nxt = 20'h0;
      if (sil_ch_r != 8'hff) begin
        sil_ch_nxt = sil_ch_r + 8'h1;
      end
    end
    if (held_r && sil_ch_r >= pkt_to_r) begin
      send_nxt = 1'b1; // RULE_10
      held_nxt = 1'b0;
    end
    if (ch_valid || line_busy) begin
      sil_cyc_nxt = 20'h0;
      sil_ch_nxt = 8'h0;
    end
    if (ch_valid && !cmd_mode_r) begin
      held_nxt = (pkt_to_r != 8'h0);
      send_nxt = (pkt_to_r == 8'h0); // RULE_12
    end
    if (!transp || cmd_mode_r) begin
      held_nxt = 1'b0; // RULE_13
      send_nxt = 1'b0;
    end
    ftype_nxt = 8'h00;
    if (!transp) begin
      ftype_nxt = (opt_r == 8'h00) ? `FRAME_NATIVE : `FRAME_EXPLICIT; // RULE_02
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sil_cyc_r <= 20'h0;
      sil_ch_r <= 8'h0;
      held_r <= 1'b0;
      pkt_send_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_cmd_o <= 1'b0;
      frame_type_o <= 8'h00;
      cmd_mode_o <= 1'b0;
      rts_o <= 1'b0;
      rts_oe_o <= 1'b0;
    end else begin
      sil_cyc_r <= sil_cyc_nxt;
      sil_ch_r <= sil_ch_nxt;
      held_r <= held_nxt;
      pkt_send_o <= send_nxt;
      rx_data_o <= ch_valid ? ch : rx_data_o;
      rx_valid_o <= ch_valid;
      rx_cmd_o <= ch_valid ? cmd_mode_r : rx_cmd_o;
      frame_type_o <= ftype_nxt;
      cmd_mode_o <= cmd_mode_nxt;
      rts_o <= (rts_fn_nxt == 3'h5); // RULE_20
      rts_oe_o <= (rts_fn_nxt == 3'h4) || (rts_fn_nxt == 3'h5);
    end
  end

endmodule

`default_nettype wire

/* host_uart_command_mode_properties.sv */
/*
  Checker for the host serial port, watching only the top ports.
  Assumes it is bound into host_uart_command_mode with its MS_CYCLES.
*/
`timescale 1ns/100ps
`default_nettype none
module host_uart_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic cmd_ok_i,
  input wire logic rts_oe_o,
  input wire logic rx_valid_o,
  input wire logic pkt_send_o,
  input wire logic [7:0] frame_type_o,
  input wire logic cmd_mode_o
);
  int quiet_r;
  int held_r;
  logic wr_req;
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i;
  // Saturate so a long idle line cannot wrap the count
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      quiet_r <= 0;
      held_r <= 0;
    end else begin
      quiet_r <= !rxd_i ? 0 : (quiet_r < 100000 ? quiet_r + 1 : quiet_r);
      held_r <= (cmd_mode_o && !cmd_ok_i) ? held_r + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_frame_type_legal: assert property (frame_type_o inside {8'h00, 8'h90, 8'h91})
    else $error("illegal frame type");
  a_pkt_transparent: assert property (pkt_send_o |-> frame_type_o == 8'h00 && !cmd_mode_o)
    else $error("packet outside transparent mode");
  a_pkt_one_pulse: assert property (pkt_send_o |=> !pkt_send_o)
    else $error("packet pulse too long");
  a_valid_spaced: assert property (rx_valid_o |=> !rx_valid_o [*8])
    else $error("characters closer than a frame");
  a_guard_after: assert property ($rose(cmd_mode_o) |-> quiet_r >= 2 * MS_CYCLES)
    else $error("command mode without trailing silence");
  a_cmd_timeout: assert property ($fell(cmd_mode_o) |->
    held_r >= 100 * MS_CYCLES || $past(wr_req) || $past(wr_req, 2))
    else $error("command mode left early");
  a_rts_on_write: assert property ($changed(rts_oe_o) |->
    $past(wr_req) || $past(wr_req, 2))
    else $error("pin enable moved without a write");
  c_cmd_entry: cover property ($rose(cmd_mode_o));
  c_packet: cover property (pkt_send_o);
  c_explicit: cover property (frame_type_o == 8'h91);
endmodule
`default_nettype wire

/* host_uart_model.sv */
/*
  Host microcontroller transmitter driving the port's receive line.
  Assumes the bench hands it the framing currently active in the port.
*/
`timescale 1ns/100ps
`default_nettype none
module host_uart_model (
  input wire logic clk_i,
  output logic txd_o
);
  // The host drives its line high between frames
  initial txd_o = 1'b1;
  task automatic send_char(input logic [7:0] d, input int div,
                           input logic [1:0] par, input logic two,
                           input logic bad);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < 8; i++) begin
      q.push_back(d[i]);
    end
    if (par != 2'h0) begin
      q.push_back(^d ^ (par == 2'h2) ^ bad);
    end
    q.push_back(1'b1);
    if (two) begin
      q.push_back(1'b1);
    end
    @(posedge clk_i);
    foreach (q[i]) begin
      txd_o <= q[i];
      repeat (div) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench for the host serial port with a host model.
  Assumes the package, design, checker and model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int MSC = 10;
  localparam int LIMIT = 40000;
  localparam logic [5:0] T_ADR [14] = '{6'h1c, 6'h1c, 6'h1c, 6'h1c,
    6'h20, 6'h20, 6'h20, 6'h20, 6'h00, 6'h08, 6'h0c, 6'h24, 6'h10, 6'h08};
  localparam logic [31:0] T_VAL [14] = '{32'h1, 32'hce5, 32'hce4, 32'h14,
    32'h1, 32'h290, 32'h28f, 32'h2, 32'h3, 32'hb, 32'h3, 32'h2, 32'h2, 32'ha};
  localparam logic [31:0] T_EXP [14] = '{32'h3e8, 32'h3e8, 32'hce4, 32'h14,
    32'h64, 32'h64, 32'h28f, 32'h2, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'ha};
  localparam logic [31:0] RST_V [10] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h0,
    32'h3, 32'h2b, 32'h3e8, 32'h64, 32'h0};
  localparam int RTS_FN [5] = '{0, 1, 3, 4, 5};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0, req = 1'b0, cmd_ok = 1'b0, rts_in = 1'b0;
  logic rxd;
  logic [31:0] rdat;
  logic ack, rts_o, rts_oe_o, rx_valid_o, rx_cmd, pkt_send_o, cmd_mode_o;
  logic [7:0] rx_data_o, frame_type_o, rx_last, esc;
  logic [31:0] rng;
  logic [1:0] par = 2'h0;
  logic two = 1'b0;
  int dv = 1042;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc_cnt = 0, pkt_cnt = 0, pkt_t = 0, val_t = 0, n;
  host_uart_command_mode #(.MS_CYCLES(MSC)) i_dut (
    .core_clk_i(clk), .arst_n_i(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd), .cmd_ok_i(cmd_ok),
    .rts_i(rts_in), .rts_o(rts_o), .rts_oe_o(rts_oe_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_cmd_o(rx_cmd),
    .pkt_send_o(pkt_send_o), .frame_type_o(frame_type_o),
    .cmd_mode_o(cmd_mode_o));
  host_uart_model i_host (.clk_i(clk), .txd_o(rxd));
  always #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int div_for(input int rate);
    return (10000000 + rate / 2) / rate;
  endfunction
  function automatic logic [31:0] ft_exp(input int a, input int o);
    return (a == 0) ? 32'h0 : ((o != 0) ? 32'h91 : 32'h90);
  endfunction
  function automatic int char_cycles();
    return dv * (10 + int'(par != 2'h0) + int'(two));
  endfunction
  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [5:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    req <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    req <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask
  // One character, checked on arrival
  task automatic send(input logic [7:0] d, input logic bad);
    i_host.send_char(d, dv, par, two, bad);
    repeat (4) @(posedge clk);
    check({24'h0, rx_last}, {24'h0, d});
  endtask
  task automatic escape_seq(input int k);
    repeat (250) @(posedge clk);
    repeat (k) send(esc, 1'b0);
    repeat (250) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (rx_valid_o === 1'b1) begin
      rx_last = rx_data_o;
      val_t = cyc_cnt;
    end
    if (pkt_send_o === 1'b1) begin
      pkt_cnt++;
      pkt_t = cyc_cnt;
    end
    if (cyc_cnt >= LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rng = 32'h00013c49;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd_chk(6'(i * 4), RST_V[i]);
    end
    rd_chk(6'h30, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(T_ADR[i], T_VAL[i]);
      rd_chk(T_ADR[i], T_EXP[i]);
    end
    wr(6'h08, 32'hec400);
    rd_chk(6'h08, 32'(10000000 / div_for(32'hec400)));
    for (int i = 12; i < 14; i++) begin
      wr(T_ADR[i], T_VAL[i]);
      rd_chk(T_ADR[i], T_EXP[i]);
    end
    for (int a = 0; a < 3; a++) begin
      for (int o = 0; o < 2; o++) begin
        wr(6'h04, 32'(o));
        wr(6'h00, 32'(a));
        repeat (3) @(posedge clk);
        check({24'h0, frame_type_o}, ft_exp(a, o));
      end
    end
    wr(6'h00, 32'h0);
    foreach (RTS_FN[i]) begin
      rng = xs(rng);
      rts_in <= rng[0];
      wr(6'h24, 32'(RTS_FN[i]));
      repeat (3) @(posedge clk);
      check({rts_oe_o, rts_o}, {RTS_FN[i] > 3, RTS_FN[i] == 5});
      rd_chk(6'h2c, {30'h0, rts_in, 1'b0});
    end
    wr(6'h0c, 32'h1);
    wr(6'h10, 32'h1);
    wr(6'h14, 32'h0);
    wr(6'h28, 32'h1);
    dv = div_for(921600);
    par = 2'h1;
    two = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      send(rng[7:0], rng[8]);
      check(32'(pkt_t - val_t), 32'h0);
    end
    wr(6'h14, 32'h2);
    n = pkt_cnt;
    send(rng[15:8], 1'b0);
    send(rng[23:16], 1'b0);
    repeat (3 * char_cycles()) @(posedge clk);
    check(32'(pkt_cnt - n), 32'h1);
    n = pkt_t - val_t - 2 * char_cycles();
    check(32'(n >= -2 * dv && n <= 2 * dv), 32'h1);
    wr(6'h00, 32'h1);
    n = pkt_cnt;
    send(rng[31:24], 1'b0);
    repeat (3 * char_cycles()) @(posedge clk);
    check(32'(pkt_cnt - n), 32'h0);
    wr(6'h00, 32'h0);
    wr(6'h14, 32'h0);
    rng = xs(rng);
    esc = {2'h1, rng[5:0]};
    wr(6'h18, {24'h0, esc});
    escape_seq(2);
    check(32'(cmd_mode_o), 32'h0);
    escape_seq(3);
    check(32'(cmd_mode_o), 32'h1);
    repeat (1250) @(posedge clk);
    cmd_ok <= 1'b1;
    @(posedge clk);
    cmd_ok <= 1'b0;
    repeat (900) @(posedge clk);
    check(32'(cmd_mode_o), 32'h1);
    repeat (1300) @(posedge clk);
    check(32'(cmd_mode_o), 32'h0);
    escape_seq(3);
    wr(6'h0c, 32'h0);
    send(rng[15:8], 1'b1);
    check(32'(rx_cmd), 32'h1);
    wr(6'h28, 32'h1);
    repeat (3) @(posedge clk);
    check(32'(cmd_mode_o), 32'h0);
    par = 2'h0;
    send(rng[23:16], 1'b0);
    wrap_up();
  end
endmodule
bind host_uart_command_mode host_uart_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .core_clk_i, .arst_n_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .rxd_i, .cmd_ok_i, .rts_oe_o, .rx_valid_o, .pkt_send_o,
  .frame_type_o, .cmd_mode_o);
`default_nettype wire
